// ===== icd_divider.sv
`timescale 1ns/1ps
module icd_divider
  import icd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic sample_clk_in,
  input wire logic sync_in,
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  output logic conv_clk_out,
  output logic duty_cycle_stabiliser_out,
  output logic stab_locked_out,
  output logic sync_done_out
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [2:0] clk_sync;
  logic [2:0] sync_sync;
  logic clk_level;
  logic sync_level;
  logic [2:0] next_clk_sync;
  logic [2:0] next_sync_sync;
  logic next_clk_level;
  logic next_sync_level;

  // Shift both pins in; a level counts once stages two and three agree.
  always_comb
  begin
    next_clk_sync = {clk_sync[1:0], sample_clk_in};
    next_sync_sync = {sync_sync[1:0], sync_in};
    next_clk_level = (clk_sync[1] == clk_sync[2]) ? clk_sync[2] : clk_level;
    next_sync_level = (sync_sync[1] == sync_sync[2]) ? sync_sync[2] : sync_level;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      clk_sync <= 3'h0;
      sync_sync <= 3'h0;
      clk_level <= 1'b0;
      sync_level <= 1'b0;
    end
    else
    begin
      clk_sync <= next_clk_sync;
      sync_sync <= next_sync_sync;
      clk_level <= next_clk_level;
      sync_level <= next_sync_level;
    end
  end

  wire logic clk_rise = next_clk_level & ~clk_level;
  wire logic sync_rise = next_sync_level & ~sync_level;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] sync_ctrl;
  logic [7:0] clock_ctrl;
  logic armed;
  logic [7:0] next_sync_ctrl;
  logic [7:0] next_clock_ctrl;
  logic next_armed;
  logic [7:0] next_rdata;
  logic sync_accept;
  logic [7:0] status_word;

  // A sync is taken when enabled and, in once-only mode, while armed.
  always_comb
  begin
    sync_accept = sync_rise & sync_ctrl[icd_sync_en_bit] & (~sync_ctrl[icd_sync_once_bit] | armed);
    next_sync_ctrl = sync_ctrl;
    next_clock_ctrl = clock_ctrl;
    next_armed = armed;
    if (sync_accept)
    begin
      next_armed = 1'b0;
    end
    if (write_in && addr_in == icd_sync_ctrl_addr)
    begin
      next_sync_ctrl = wdata_in;
      next_armed = 1'b1;
    end
    if (write_in && addr_in == icd_clock_ctrl_addr)
    begin
      next_clock_ctrl = {4'h0, wdata_in[3:0]};
    end
    next_rdata = 8'h00;
    if (read_in)
    begin
      unique case (addr_in)
        icd_sync_ctrl_addr: next_rdata = sync_ctrl;
        icd_clock_ctrl_addr: next_rdata = clock_ctrl;
        icd_status_addr: next_rdata = status_word;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      sync_ctrl <= icd_sync_ctrl_reset;
      clock_ctrl <= icd_clock_ctrl_reset;
      armed <= 1'b0;
      rdata_out <= 8'h00;
    end
    else
    begin
      sync_ctrl <= next_sync_ctrl;
      clock_ctrl <= next_clock_ctrl;
      armed <= next_armed;
      rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  logic [2:0] ratio_m1;
  logic [2:0] div_count;
  logic [2:0] next_div_count;
  logic div_tick;
  logic [3:0] ratio_count;

  // Ratio field holds the ratio minus one, giving one to eight.
  assign ratio_m1 = clock_ctrl[icd_ratio_lsb +: 3];

  // Widen before adding one so that a ratio of eight does not wrap to zero.
  assign ratio_count = {1'b0, ratio_m1} + 4'h1;

  // Count input rising edges; a valid sync restores the initial count.
  always_comb
  begin
    next_div_count = div_count;
    div_tick = 1'b0;
    if (sync_accept)
    begin
      next_div_count = 3'h0;
    end
    else if (clk_rise)
    begin
      div_tick = (div_count == 3'h0);
      next_div_count = (div_count >= ratio_m1) ? 3'h0 : div_count + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      div_count <= 3'h0;
    end
    else
    begin
      div_count <= next_div_count;
    end
  end

  // ----------------------------------------------------------------
  // Rate monitor and stabiliser
  // ----------------------------------------------------------------
  logic [15:0] period;
  logic [15:0] last_period;
  logic [15:0] hold_period;
  logic [15:0] high_count;
  logic [15:0] relock;
  logic [8:0] win_count;
  logic [8:0] edge_count;
  logic rate_ok;
  logic conv_level;
  logic stab_on;
  logic locked;
  logic [15:0] next_period;
  logic [15:0] next_last_period;
  logic [15:0] next_hold_period;
  logic [15:0] next_high_count;
  logic [15:0] next_relock;
  logic [8:0] next_win_count;
  logic [8:0] next_edge_count;
  logic next_rate_ok;
  logic next_conv_level;
  logic next_locked;
  logic rate_change;

  // Stabiliser is on when enabled or when the ratio is not one.
  assign stab_on = clock_ctrl[icd_dcs_en_bit] | (ratio_m1 != 3'h0);

  always_comb
  begin
    next_period = (period == 16'hffff) ? period : period + 16'h1;
    next_last_period = last_period;
    next_hold_period = hold_period;
    rate_change = 1'b0;
    if (clk_rise)
    begin
      next_period = 16'h1;
      next_last_period = period;
      rate_change = (period > last_period + 16'h2) || (period + 16'h2 < last_period);
      if (div_tick)
      begin
        next_hold_period = period * {12'h0, ratio_count};
      end
    end
    // Edge count over a fixed window tells whether the loop can run.
    next_win_count = win_count + 9'h1;
    next_edge_count = edge_count + {8'h0, clk_rise};
    next_rate_ok = rate_ok;
    if (win_count == 9'(icd_rate_window - 1))
    begin
      next_win_count = 9'h0;
      next_edge_count = 9'h0;
      next_rate_ok = (edge_count >= 9'(icd_min_edges));
    end
    // A rate change holds the loop out of lock for the relock time.
    next_relock = (relock != 16'h0) ? relock - 16'h1 : relock;
    if (rate_change)
    begin
      next_relock = 16'(icd_relock_cycles);
    end
    next_locked = stab_on & rate_ok & (relock == 16'h0);
    next_high_count = (high_count != 16'h0) ? high_count - 16'h1 : high_count;
    next_conv_level = conv_level;
    if (div_tick)
    begin
      next_conv_level = 1'b1;
      next_high_count = {1'b0, next_hold_period[15:1]};
    end
    else if (locked && high_count == 16'h1)
    begin
      next_conv_level = 1'b0;
    end
    // Follow the next synchronised level, as the rise does, so the raw duty is not stretched.
    else if (!locked && ratio_m1 == 3'h0 && !next_clk_level)
    begin
      next_conv_level = 1'b0;
    end
    else if (!locked && ratio_m1 != 3'h0 && clk_rise && div_count == 3'h1)
    begin
      next_conv_level = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      period <= 16'h0;
      last_period <= 16'h0;
      hold_period <= 16'h0;
      high_count <= 16'h0;
      relock <= 16'h0;
      win_count <= 9'h0;
      edge_count <= 9'h0;
      rate_ok <= 1'b0;
      conv_level <= 1'b0;
      locked <= 1'b0;
    end
    else
    begin
      period <= next_period;
      last_period <= next_last_period;
      hold_period <= next_hold_period;
      high_count <= next_high_count;
      relock <= next_relock;
      win_count <= next_win_count;
      edge_count <= next_edge_count;
      rate_ok <= next_rate_ok;
      conv_level <= next_conv_level;
      locked <= next_locked;
    end
  end

  assign status_word = {4'h0, armed, rate_ok, locked, stab_on};

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      conv_clk_out <= 1'b0;
      duty_cycle_stabiliser_out <= 1'b0;
      stab_locked_out <= 1'b0;
      sync_done_out <= 1'b0;
    end
    else
    begin
      conv_clk_out <= conv_level;
      duty_cycle_stabiliser_out <= stab_on;
      stab_locked_out <= locked;
      sync_done_out <= sync_accept;
    end
  end

endmodule : icd_divider

// ===== icd_pkg.sv
package icd_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [8:0] icd_sync_ctrl_addr = 9'h100;
  localparam logic [8:0] icd_clock_ctrl_addr = 9'h101;
  localparam logic [8:0] icd_status_addr = 9'h102;
  localparam int icd_sync_en_bit = 1;
  localparam int icd_sync_once_bit = 2;
  localparam int icd_dcs_en_bit = 0;
  localparam int icd_ratio_lsb = 1;
  localparam logic [7:0] icd_sync_ctrl_reset = 8'h00;
  localparam logic [7:0] icd_clock_ctrl_reset = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int icd_clk_mhz = 100;
  localparam int icd_relock_ns = 5000;
  localparam int icd_relock_cycles = (icd_relock_ns * icd_clk_mhz) / 1000;
  localparam int icd_low_rate_mhz = 20;
  localparam int icd_rate_window = 256;
  localparam int icd_min_edges = (icd_low_rate_mhz * icd_rate_window) / icd_clk_mhz;

endpackage : icd_pkg

// ===== icd_monitor.sv
`timescale 1ns/1ps
module icd_monitor
  import icd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic sample_clk_in,
  input wire logic sync_in,
  input wire logic [8:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [7:0] rdata_out,
  input wire logic conv_clk_out,
  input wire logic duty_cycle_stabiliser_out,
  input wire logic stab_locked_out,
  input wire logic sync_done_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  logic sync_en;
  logic next_sync_en;
  logic wr_clk;
  // Keeps a copy of the sync enable bit as software writes it.
  always_comb
  begin
    wr_clk = write_in && addr_in == icd_clock_ctrl_addr;
    next_sync_en = sync_en;
    if (reset_in)
    begin
      next_sync_en = 1'b0;
    end
    else if (write_in && addr_in == icd_sync_ctrl_addr)
    begin
      next_sync_en = wdata_in[icd_sync_en_bit];
    end
  end
  // Registers the copy.
  always_ff @(posedge ref_clk_in)
  begin
    sync_en <= next_sync_en;
  end
  property p_rd_map; rdata_out != 8'h00 |-> $past(read_in) && $past(addr_in) inside {[9'h100:9'h102]}; endproperty
  a_rd_map: assert property (p_rd_map) else $error("data from no mapped read");
  property p_rd_idle; !$past(read_in) |-> rdata_out == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_dcs_on; wr_clk && wdata_in[3:1] != 3'h0 |-> ##2 duty_cycle_stabiliser_out; endproperty
  a_dcs_on: assert property (p_dcs_on) else $error("stabiliser not forced on");
  property p_dcs_off; wr_clk && wdata_in[3:0] == 4'h0 |-> ##2 !duty_cycle_stabiliser_out; endproperty
  a_dcs_off: assert property (p_dcs_off) else $error("stabiliser on while off");
  property p_sync_lat; sync_done_out |-> $past(sync_in, 3) || $past(sync_in, 4); endproperty
  a_sync_lat: assert property (p_sync_lat) else $error("realign without sync pulse");
  property p_done_pulse; sync_done_out |=> !sync_done_out; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("realign pulse too long");
  property p_sync_off; sync_done_out |-> sync_en; endproperty
  a_sync_off: assert property (p_sync_off) else $error("realign while sync disabled");
  property p_lock_dcs; stab_locked_out |-> duty_cycle_stabiliser_out || $past(duty_cycle_stabiliser_out); endproperty
  a_lock_dcs: assert property (p_lock_dcs) else $error("locked while bypassed");
  c_done: cover property (sync_done_out);
  c_lock: cover property ($rose(stab_locked_out));
  c_dcs: cover property ($rose(duty_cycle_stabiliser_out));
endmodule : icd_monitor
bind icd_divider icd_monitor mon (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .sample_clk_in(sample_clk_in),
  .sync_in(sync_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .write_in(write_in),
  .read_in(read_in),
  .rdata_out(rdata_out),
  .conv_clk_out(conv_clk_out),
  .duty_cycle_stabiliser_out(duty_cycle_stabiliser_out),
  .stab_locked_out(stab_locked_out),
  .sync_done_out(sync_done_out)
);

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top
  import icd_pkg::*;
;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic sample_clk_in = 1'b0;
  logic sync_in = 1'b0;
  logic [8:0] addr_in = 9'h000;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic [7:0] rdata_out;
  logic conv_clk_out;
  logic duty_cycle_stabiliser_out;
  logic stab_locked_out;
  logic sync_done_out;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  int hi = 2;
  int lo = 2;
  int ph = 0;
  int c;
  int e;
  int t0 = 0;
  logic [19:0] p1;
  logic [19:0] p2;
  logic run = 1'b0;
  icd_divider uut (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .sample_clk_in(sample_clk_in),
    .sync_in(sync_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .conv_clk_out(conv_clk_out),
    .duty_cycle_stabiliser_out(duty_cycle_stabiliser_out),
    .stab_locked_out(stab_locked_out),
    .sync_done_out(sync_done_out)
  );
  // Makes the system clock.
  initial
  begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // Makes the sample clock with hi and lo cycles, and cuts a hung run short.
  always @(posedge ref_clk_in)
  begin
    ph <= (ph + 1 >= hi + lo) ? 0 : ph + 1;
    sample_clk_in <= run && (ph < hi);
    cyc <= cyc + 1;
    if (cyc == 45000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task complete_run;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [15:0] g, input logic [15:0] w);
    compares++;
    if (g !== w)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, g, w);
    end
  endtask : chk
  task wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    write_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge ref_clk_in);
    write_in <= 1'b0;
  endtask : wr
  task rd(input logic [8:0] a, input logic [7:0] w);
    @(posedge ref_clk_in);
    read_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    read_in <= 1'b0;
    @(negedge ref_clk_in);
    chk({8'h00, rdata_out}, {8'h00, w});
  endtask : rd
  task sp(input logic [15:0] w);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    sync_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sync_in <= 1'b0;
    repeat (12) @(negedge ref_clk_in) n += (sync_done_out === 1'b1);
    chk(16'(n), w);
  endtask : sp
  // Counts high cycles (m 0) or rising edges (m 1) of the conversion clock.
  task cnt(input int k, input int m);
    logic pv;
    c = 0;
    pv = conv_clk_out;
    repeat (k)
    begin
      @(negedge ref_clk_in);
      c += m ? (conv_clk_out === 1'b1 && pv === 1'b0) : (conv_clk_out === 1'b1);
      pv = conv_clk_out;
    end
  endtask : cnt
  task lk(input int k, input logic w);
    repeat (k) @(negedge ref_clk_in);
    chk({15'h0000, stab_locked_out}, {15'h0000, w});
  endtask : lk
  // Sends a sync at a fixed sample clock phase, gap cycles modulo 20 after the last one, and records 20 cycles.
  task sa(input int gap, output logic [19:0] p);
    do
    begin
      @(posedge ref_clk_in);
    end
    while (ph != 0 || (gap >= 0 && (cyc - t0) % 20 != gap));
    t0 = cyc;
    sync_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    sync_in <= 1'b0;
    repeat (12) @(negedge ref_clk_in);
    for (int i = 0; i < 20; i++)
    begin
      @(negedge ref_clk_in);
      p[i] = conv_clk_out;
    end
  endtask : sa
  // Runs the tests in order.
  initial
  begin
    repeat (2) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    rd(icd_sync_ctrl_addr, icd_sync_ctrl_reset);
    rd(icd_clock_ctrl_addr, icd_clock_ctrl_reset);
    rd(9'h1ff, 8'h00);
    rd(icd_status_addr, 8'h01);
    lk(700, 1'b0);
    $display("test registers done");
    run = 1'b1;
    for (int r = 1; r <= 8; r++)
    begin
      wr(icd_clock_ctrl_addr, 8'((r - 1) << 1));
      rd(icd_clock_ctrl_addr, 8'((r - 1) << 1));
      chk({15'h0000, duty_cycle_stabiliser_out}, 16'(r != 1));
      repeat (40) @(negedge ref_clk_in);
      cnt(3360, 1);
      e = 840 / r;
      chk(16'(c + 1 >= e && c <= e + 1), 16'h0001);
    end
    $display("test ratios done");
    hi = 3;
    lo = 2;
    wr(icd_clock_ctrl_addr, 8'h01);
    lk(1200, 1'b1);
    rd(icd_status_addr, 8'h07);
    cnt(50, 0);
    chk(16'(c), 16'h0014);
    hi = 3;
    lo = 9;
    lk(1000, 1'b0);
    cnt(48, 0);
    chk(16'(c), 16'h000c);
    hi = 3;
    lo = 2;
    lk(140, 1'b0);
    lk(1100, 1'b1);
    $display("test stabiliser done");
    wr(icd_sync_ctrl_addr, 8'h02);
    sp(16'h0001);
    sp(16'h0001);
    wr(icd_clock_ctrl_addr, 8'h07);
    sa(-1, p1);
    sa(10, p2);
    chk(16'($countones(p1)), 16'h000a);
    chk(16'(p2 == p1), 16'h0001);
    wr(icd_sync_ctrl_addr, 8'h06);
    sp(16'h0001);
    sp(16'h0000);
    wr(icd_sync_ctrl_addr, 8'h06);
    sp(16'h0001);
    wr(icd_sync_ctrl_addr, 8'h00);
    sp(16'h0000);
    $display("test sync done");
    complete_run();
  end
endmodule : tb_top
